// ==== rtl/dms_core.sv ====
// Fetch and execute sequencer of a small 8-bit core.
// Assumes memory answers reads combinationally in the cycle the address
// is driven and takes a write in the strobe cycle.
//
// How it works
// - opcode b7 is two-byte direct accumulator store
// - direct address upper byte forced to 00
// - direct store takes four cycles
// - cycle one reads opcode, advances program counter
// - cycle two reads low address byte
// - cycle three builds address, advances counter
// - cycle four writes accumulator with strobe
// - b6 direct load, a6 immediate load
// - opcode sets operand count, consumed in order
// - branch target is counter plus signed offset
// - code runs from any memory type
// - instructions take one to four cycles
// - immediate load completes in two cycles
// - loads set zero and negative flags
`timescale 1ns/1ps
`default_nettype none

module dms_core #(
  parameter int ADDR_W = dms_pkg::ADDR_W,
  parameter int DATA_W = dms_pkg::DATA_W
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Memory port
  input wire logic [7:0] i_mem_rdata,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_we,
  // Core state
  output logic o_sync,
  output logic [7:0] o_acc,
  output logic o_flag_z,
  output logic o_flag_n
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  // The direct page build assumes exactly a 16-bit address and byte data
  if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_width
    $error("dms_core supports only 16-bit address and 8-bit data");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  dms_pkg::dms_state_t state_ff, nxt_state;  // Sequencer step
  dms_pkg::dms_class_t cls_ff, nxt_cls;      // Class of current instruction
  logic [7:0] opcode_ff, nxt_opcode;         // Current opcode
  logic [15:0] pc_ff, nxt_pc;                // Program counter
  logic [7:0] ea_lo_ff, nxt_ea_lo;           // Low byte of direct address
  logic [1:0] skip_ff, nxt_skip;             // Operand bytes left to consume
  logic [7:0] acc_ff, nxt_acc;               // Accumulator
  logic z_ff, nxt_z;                         // Zero flag
  logic n_ff, nxt_n;                         // Negative flag
  logic [15:0] addr_ff, nxt_addr;            // Address bus register
  logic [7:0] wdata_ff, nxt_wdata;           // Data bus register
  logic we_ff, nxt_we;                       // Write strobe register
  logic sync_ff, nxt_sync;                   // Opcode fetch marker

  // Decoder outputs
  dms_pkg::dms_class_t dec_cls;
  logic [1:0] dec_cnt;

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Branch condition from opcode and flags
  function automatic logic br_taken(input logic [7:0] op, input logic z, input logic n);
    logic t;
    t = 1'b0;
    unique case (op)
      dms_pkg::OP_BR_ALWAYS: t = 1'b1;
      dms_pkg::OP_BR_NEVER: t = 1'b0;
      dms_pkg::OP_BR_NE: t = ~z;
      dms_pkg::OP_BR_EQ: t = z;
      dms_pkg::OP_BR_PL: t = ~n;
      dms_pkg::OP_BR_MI: t = n;
      default: t = 1'b0;                   // Flags not modelled here
    endcase
    return t;
  endfunction

  // Full direct address from its low byte
  function automatic logic [15:0] direct_addr(input logic [7:0] lo);
    return {dms_pkg::DIRECT_PAGE_HI, lo};
  endfunction

  // ==========================================================================
  // Opcode decoder
  // ==========================================================================
  dms_opdecode u_dec (
    .i_opcode(i_mem_rdata),
    .o_class(dec_cls),
    .o_opnd_cnt(dec_cnt)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // One step per clock; addresses for the next cycle are prepared here so
  // the bus pins come straight from flip-flops
  always_comb begin
    nxt_state = state_ff;
    nxt_cls = cls_ff;
    nxt_opcode = opcode_ff;
    nxt_pc = pc_ff;
    nxt_ea_lo = ea_lo_ff;
    nxt_skip = skip_ff;
    nxt_acc = acc_ff;
    nxt_z = z_ff;
    nxt_n = n_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    nxt_sync = 1'b0;
    unique case (state_ff)
      // Opcode read from any memory, counter advanced
      dms_pkg::DMS_ST_FETCH: begin
        nxt_opcode = i_mem_rdata;
        nxt_cls = dec_cls;
        nxt_pc = pc_ff + dms_pkg::PC_STEP;
        nxt_addr = pc_ff + dms_pkg::PC_STEP;
        if (dec_cnt == 2'd0) begin
          nxt_state = dms_pkg::DMS_ST_FETCH;           // One-byte instruction
          nxt_sync = 1'b1;
        end else begin
          nxt_skip = dec_cnt - 2'd1;
          nxt_state = dms_pkg::DMS_ST_OPND;
        end
      end
      // First operand read at the counter
      dms_pkg::DMS_ST_OPND: begin
        nxt_ea_lo = i_mem_rdata;
        if (cls_ff == dms_pkg::DMS_CLS_LDA_IMM) begin
          nxt_acc = i_mem_rdata;
          nxt_z = (i_mem_rdata == 8'h00);
          nxt_n = i_mem_rdata[7];
          nxt_pc = pc_ff + dms_pkg::PC_STEP;
          nxt_addr = pc_ff + dms_pkg::PC_STEP;
          nxt_state = dms_pkg::DMS_ST_FETCH;
          nxt_sync = 1'b1;
        end else if (cls_ff == dms_pkg::DMS_CLS_SKIP) begin
          nxt_pc = pc_ff + dms_pkg::PC_STEP;
          nxt_addr = pc_ff + dms_pkg::PC_STEP;
          if (skip_ff == 2'd0) begin
            nxt_state = dms_pkg::DMS_ST_FETCH;
            nxt_sync = 1'b1;
          end else begin
            nxt_state = dms_pkg::DMS_ST_SKIP;
          end
        end else begin
          nxt_state = dms_pkg::DMS_ST_CALC;            // Counter held this cycle
        end
      end
      // Address build and counter advance
      dms_pkg::DMS_ST_CALC: begin
        nxt_pc = pc_ff + dms_pkg::PC_STEP;
        if (cls_ff == dms_pkg::DMS_CLS_BRANCH) begin
          if (br_taken(opcode_ff, z_ff, n_ff)) begin
            nxt_pc = pc_ff + dms_pkg::PC_STEP + {{8{ea_lo_ff[7]}}, ea_lo_ff};
          end
          nxt_addr = nxt_pc;
          nxt_state = dms_pkg::DMS_ST_FETCH;
          nxt_sync = 1'b1;
        end else begin
          nxt_addr = direct_addr(ea_lo_ff);
          nxt_wdata = acc_ff;
          nxt_we = (cls_ff == dms_pkg::DMS_CLS_STA_DIR);
          nxt_state = dms_pkg::DMS_ST_XFER;
        end
      end
      // Data memory cycle: write for the store, read for the load
      dms_pkg::DMS_ST_XFER: begin
        if (cls_ff == dms_pkg::DMS_CLS_LDA_DIR) begin
          nxt_acc = i_mem_rdata;
          nxt_z = (i_mem_rdata == 8'h00);
          nxt_n = i_mem_rdata[7];
        end
        nxt_addr = pc_ff;
        nxt_state = dms_pkg::DMS_ST_FETCH;
        nxt_sync = 1'b1;
      end
      // Trailing operand bytes of instructions without an effect here
      dms_pkg::DMS_ST_SKIP: begin
        nxt_pc = pc_ff + dms_pkg::PC_STEP;
        nxt_addr = pc_ff + dms_pkg::PC_STEP;
        nxt_skip = skip_ff - 2'd1;
        if (skip_ff == 2'd1) begin
          nxt_state = dms_pkg::DMS_ST_FETCH;
          nxt_sync = 1'b1;
        end
      end
      // Unused codes recover to a fetch at the counter
      default: begin
        nxt_addr = pc_ff;
        nxt_state = dms_pkg::DMS_ST_FETCH;
        nxt_sync = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Synchronous reset puts the first fetch at the reset counter
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state_ff <= dms_pkg::DMS_ST_FETCH;
      cls_ff <= dms_pkg::DMS_CLS_SKIP;
      opcode_ff <= 8'h00;
      pc_ff <= dms_pkg::RESET_PC;
      ea_lo_ff <= 8'h00;
      skip_ff <= 2'd0;
      acc_ff <= dms_pkg::RESET_ACC;
      z_ff <= 1'b0;
      n_ff <= 1'b0;
      addr_ff <= dms_pkg::RESET_PC;
      wdata_ff <= 8'h00;
      we_ff <= 1'b0;
      sync_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cls_ff <= nxt_cls;
      opcode_ff <= nxt_opcode;
      pc_ff <= nxt_pc;
      ea_lo_ff <= nxt_ea_lo;
      skip_ff <= nxt_skip;
      acc_ff <= nxt_acc;
      z_ff <= nxt_z;
      n_ff <= nxt_n;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      sync_ff <= nxt_sync;
    end
  end

  // Outputs straight from flip-flops
  assign o_mem_addr = addr_ff;
  assign o_mem_wdata = wdata_ff;
  assign o_mem_we = we_ff;
  assign o_sync = sync_ff;
  assign o_acc = acc_ff;
  assign o_flag_z = z_ff;
  assign o_flag_n = n_ff;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  // Fetch of a given opcode
  sequence s_fetch(logic [7:0] op);
    o_sync && i_mem_rdata == op;
  endsequence

  // Direct store: operand read then write three cycles after fetch
  sequence s_sta_write;
    ##3 (o_mem_we && o_mem_addr == {8'h00, $past(i_mem_rdata, 2)} && o_mem_wdata == o_acc);
  endsequence

  a_sta_write_data: assert property (s_fetch(8'hb7) |-> s_sta_write)
    else $error("direct store did not write accumulator to page zero");

  a_sta_operand_addr: assert property (s_fetch(8'hb7)
      |=> (o_mem_addr == $past(o_mem_addr) + 16'h0001) && !o_mem_we)
    else $error("operand read not at next location");

  a_sta_four_cycles: assert property (s_fetch(8'hb7)
      |-> ##1 !o_sync [*3] ##1 (o_sync && o_mem_addr == $past(o_mem_addr, 4) + 16'h0002))
    else $error("direct store not four cycles or counter wrong");

  a_lda_imm_two: assert property (s_fetch(8'ha6)
      |-> ##2 (o_sync && o_acc == $past(i_mem_rdata) && o_mem_addr == $past(o_mem_addr, 2) + 16'h0002))
    else $error("immediate load wrong");

  a_load_flags: assert property ((s_fetch(8'ha6) or s_fetch(8'hb6))
      |-> ##[2:4] (o_sync && o_flag_z == (o_acc == 8'h00) && o_flag_n == o_acc[7]))
    else $error("load flags wrong");

  a_lda_dir_read: assert property (s_fetch(8'hb6)
      |-> ##3 (!o_mem_we && o_mem_addr[15:8] == 8'h00) ##1 (o_sync && o_acc == $past(i_mem_rdata)))
    else $error("direct load wrong");

  // Offset byte sign-extended and added to the address after the branch
  a_branch_always: assert property (s_fetch(8'h20)
      |-> ##3 (o_sync && o_mem_addr == $past(o_mem_addr, 3) + 16'h0002
               + {{8{$past(i_mem_rdata[7], 2)}}, $past(i_mem_rdata, 2)}))
    else $error("branch target wrong");

  // Every three-byte group: bit test, extended and 16-bit offset forms
  a_skip_three_bytes: assert property ((o_sync && i_mem_rdata[7:4] inside {4'h0, 4'hc, 4'hd})
      |-> ##3 (o_sync && o_mem_addr == $past(o_mem_addr, 3) + 16'h0003))
    else $error("three-byte instruction misaligned");

  a_write_only_store: assert property (o_mem_we |-> state_ff == dms_pkg::DMS_ST_XFER && cls_ff == dms_pkg::DMS_CLS_STA_DIR)
    else $error("write strobe outside direct store");

endmodule

`default_nettype wire

// ==== rtl/dms_pkg.sv ====
// Shared constants and types for the direct mode store sequencer.
// Assumes a single 200 MHz system clock and a byte-wide memory partner.
package dms_pkg;

  // ==========================================================================
  // Bus widths
  // ==========================================================================
  localparam int ADDR_W = 16;                   // Internal address bus width
  localparam int DATA_W = 8;                    // Internal data bus width

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] RESET_PC = 16'h0000;  // Program counter after reset
  localparam logic [7:0] RESET_ACC = 8'h00;     // Accumulator after reset

  // ==========================================================================
  // Addressing constants
  // ==========================================================================
  localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;  // Upper byte of every direct address
  localparam logic [15:0] PC_STEP = 16'h0001;     // Program counter advance per byte

  // ==========================================================================
  // Opcodes the sequencer executes
  // ==========================================================================
  localparam logic [7:0] OP_STA_DIR = 8'hb7;    // Store accumulator, direct
  localparam logic [7:0] OP_LDA_DIR = 8'hb6;    // Load accumulator, direct
  localparam logic [7:0] OP_LDA_IMM = 8'ha6;    // Load accumulator, immediate
  localparam logic [7:0] OP_BR_ALWAYS = 8'h20;  // Branch always
  localparam logic [7:0] OP_BR_NEVER = 8'h21;   // Branch never
  localparam logic [7:0] OP_BR_NE = 8'h26;      // Branch if zero flag clear
  localparam logic [7:0] OP_BR_EQ = 8'h27;      // Branch if zero flag set
  localparam logic [7:0] OP_BR_PL = 8'h2a;      // Branch if negative flag clear
  localparam logic [7:0] OP_BR_MI = 8'h2b;      // Branch if negative flag set

  // ==========================================================================
  // Instruction classes from the decoder
  // ==========================================================================
  typedef enum logic [2:0] {
    DMS_CLS_SKIP = 3'h0,       // Operands consumed, no effect
    DMS_CLS_STA_DIR = 3'h1,    // Direct store of the accumulator
    DMS_CLS_LDA_DIR = 3'h2,    // Direct load of the accumulator
    DMS_CLS_LDA_IMM = 3'h3,    // Immediate load of the accumulator
    DMS_CLS_BRANCH = 3'h4      // Relative branch
  } dms_class_t;

  // ==========================================================================
  // Sequencer states, Gray coded along fetch, operand, calc, transfer
  // ==========================================================================
  typedef enum logic [2:0] {
    DMS_ST_FETCH = 3'b000,     // Opcode read at the program counter
    DMS_ST_OPND = 3'b001,      // First operand read
    DMS_ST_CALC = 3'b011,      // Internal address build
    DMS_ST_XFER = 3'b010,      // Data memory write or read
    DMS_ST_SKIP = 3'b110       // Remaining operand bytes consumed
  } dms_state_t;

endpackage

// ==== rtl/dms_opdecode.sv ====
// Opcode decoder: instruction class and operand byte count.
// Assumes the opcode is stable for the cycle it is decoded in.
`timescale 1ns/1ps
`default_nettype none

module dms_opdecode (
  // Opcode in
  input wire logic [7:0] i_opcode,
  // Decode out
  output dms_pkg::dms_class_t o_class,
  output logic [1:0] o_opnd_cnt
);

  // ==========================================================================
  // Class and operand count from the opcode
  // ==========================================================================
  // Count follows the opcode map by column group
  always_comb begin
    o_class = dms_pkg::DMS_CLS_SKIP;
    unique case (i_opcode[7:4])
      4'h0: o_opnd_cnt = 2'd2;                  // Bit test and branch
      4'h1, 4'h2, 4'h3, 4'h6, 4'ha, 4'hb, 4'he: o_opnd_cnt = 2'd1;
      4'hc, 4'hd: o_opnd_cnt = 2'd2;            // Extended, 16-bit index offset
      default: o_opnd_cnt = 2'd0;               // Inherent and plain indexed
    endcase
    if (i_opcode == dms_pkg::OP_STA_DIR) begin
      o_class = dms_pkg::DMS_CLS_STA_DIR;
    end else if (i_opcode == dms_pkg::OP_LDA_DIR) begin
      o_class = dms_pkg::DMS_CLS_LDA_DIR;
    end else if (i_opcode == dms_pkg::OP_LDA_IMM) begin
      o_class = dms_pkg::DMS_CLS_LDA_IMM;
    end else if (i_opcode[7:4] == 4'h2) begin
      o_class = dms_pkg::DMS_CLS_BRANCH;
    end
  end

endmodule

`default_nettype wire

// ==== verif/dms_mem_model.sv ====
// Behavioural program and data memory facing the sequencer's memory port.
// Assumes one clock shared with the core; reads are combinational.
`timescale 1ns/1ps
`default_nettype none

module dms_mem_model (
  // Clock
  input wire logic i_clk,
  // Bus from the core
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  // Read data to the core
  output logic [7:0] o_rdata
);
  // ==========================================================================
  // Storage
  // ==========================================================================
  // Full 64 KiB read-write space; code may live anywhere in it
  logic [7:0] mem [0:65535];

  // Read answers in the same cycle as the address, no wait states
  assign o_rdata = mem[i_addr];

  // Write lands at the edge ending the strobe cycle
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule

`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the sequencer, running short programs.
// Assumes the memory model answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic i_clk_sys = 1'b0;  // 200 MHz clock
  logic i_reset_n = 1'b0;  // Active-low reset, held from time zero
  logic [7:0] mem_rdata;  // Memory read data
  logic [15:0] mem_addr;  // Core address bus
  logic [7:0] mem_wdata;  // Core write data
  logic mem_we;  // Core write strobe
  logic sync;  // Opcode fetch marker
  logic [7:0] acc;  // Accumulator
  logic flag_z;  // Zero flag
  logic flag_n;  // Negative flag
  int error_cnt = 0;  // Mismatches seen
  int check_count = 0;  // Comparisons made

  always #2.5 i_clk_sys = ~i_clk_sys;

  // ==========================================================================
  // Instances
  // ==========================================================================
  dms_core dms_core_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_mem_rdata(mem_rdata),
    .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_we(mem_we),
    .o_sync(sync), .o_acc(acc), .o_flag_z(flag_z), .o_flag_n(flag_n)
  );

  dms_mem_model dms_mem_model_i (
    .i_clk(i_clk_sys), .i_addr(mem_addr), .i_wdata(mem_wdata),
    .i_we(mem_we), .o_rdata(mem_rdata)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Compare and count; unknowns never match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Check one non-writing bus cycle, then move to the next cycle
  task automatic bus(input logic [15:0] a, input logic s);
    chk(mem_addr, a);
    chk({15'h0, sync}, {15'h0, s});
    chk({15'h0, mem_we}, 16'h0);
    @(negedge i_clk_sys);
  endtask

  // Check accumulator and both flags against the loaded value
  task automatic chk_acc(input logic [7:0] v);
    chk({8'h00, acc}, {8'h00, v});
    chk({15'h0, flag_z}, {15'h0, (v == 8'h00)});
    chk({15'h0, flag_n}, {15'h0, v[7]});
  endtask

  // Load a program at 0000 over filler, reset; returns in the first fetch
  task automatic start(input logic [7:0] prog [$]);
    for (int i = 0; i < 65536; i++) begin
      dms_mem_model_i.mem[i] = 8'h9d;  // One-byte filler opcode
    end
    foreach (prog[i]) begin
      dms_mem_model_i.mem[i] = prog[i];
    end
    @(negedge i_clk_sys);
    i_reset_n = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
  endtask

  // Print counts and verdict, then stop
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Immediate load of zero, negative and positive values
  task automatic t_imm;
    logic [7:0] vals [3] = '{8'h00, 8'h80, 8'h7f};
    foreach (vals[k]) begin
      start('{8'ha6, vals[k]});
      bus(16'h0000, 1'b1);
      bus(16'h0001, 1'b0);
      chk_acc(vals[k]);
      bus(16'h0002, 1'b1);
    end
  endtask

  // Direct store to the top of page zero, cycle by cycle
  task automatic t_store;
    start('{8'ha6, 8'h5a, 8'hb7, 8'hff});
    bus(16'h0000, 1'b1);
    bus(16'h0001, 1'b0);
    bus(16'h0002, 1'b1);
    bus(16'h0003, 1'b0);
    bus(16'h0003, 1'b0);
    chk(mem_addr, 16'h00ff);
    chk({15'h0, mem_we}, 16'h0001);
    chk({8'h00, mem_wdata}, 16'h005a);
    chk({15'h0, sync}, 16'h0000);
    @(negedge i_clk_sys);
    bus(16'h0004, 1'b1);
    chk({8'h00, dms_mem_model_i.mem[255]}, 16'h005a);
  endtask

  // Direct load from page zero sets the flags
  task automatic t_load_dir;
    start('{8'hb6, 8'h33});
    dms_mem_model_i.mem[16'h0033] = 8'h80;
    bus(16'h0000, 1'b1);
    bus(16'h0001, 1'b0);
    bus(16'h0001, 1'b0);
    bus(16'h0033, 1'b0);
    chk_acc(8'h80);
    bus(16'h0002, 1'b1);
  endtask

  // Three-byte, one-byte and bit-test opcodes keep alignment
  task automatic t_opnd_cnt;
    start('{8'hc6, 8'h12, 8'h34, 8'h9d, 8'h00, 8'h12, 8'h34, 8'ha6, 8'h11});
    bus(16'h0000, 1'b1);
    bus(16'h0001, 1'b0);
    bus(16'h0002, 1'b0);
    bus(16'h0003, 1'b1);
    bus(16'h0004, 1'b1);
    bus(16'h0005, 1'b0);
    bus(16'h0006, 1'b0);
    bus(16'h0007, 1'b1);
    bus(16'h0008, 1'b0);
    chk_acc(8'h11);
    bus(16'h0009, 1'b1);
  endtask

  // Each modelled branch code plus unmodelled 22 under both flag settings, negative offset
  task automatic t_branch;
    logic [7:0] ops [7] = '{8'h20, 8'h21, 8'h26, 8'h27, 8'h2a, 8'h2b, 8'h22};
    logic [7:0] vals [2] = '{8'h00, 8'h80};
    logic tk;
    foreach (vals[v]) begin
      foreach (ops[k]) begin
        case (ops[k])
          8'h20: tk = 1'b1;
          8'h26: tk = (vals[v] != 8'h00);
          8'h27: tk = (vals[v] == 8'h00);
          8'h2a: tk = ~vals[v][7];
          8'h2b: tk = vals[v][7];
          default: tk = 1'b0;
        endcase
        start('{8'ha6, vals[v], ops[k], 8'hfe});
        bus(16'h0000, 1'b1);
        bus(16'h0001, 1'b0);
        bus(16'h0002, 1'b1);
        bus(16'h0003, 1'b0);
        bus(16'h0003, 1'b0);
        bus(tk ? 16'h0002 : 16'h0004, 1'b1);
      end
    end
  endtask

  // Code patched by a store into read-write memory then executed
  task automatic t_ram_code;
    start('{8'ha6, 8'ha6, 8'hb7, 8'h08});
    dms_mem_model_i.mem[9] = 8'h3c;
    repeat (12) @(negedge i_clk_sys);
    chk(mem_addr, 16'h000a);
    chk({15'h0, sync}, 16'h0001);
    chk_acc(8'h3c);
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  // ==========================================================================
  initial begin
    t_imm();
    t_store();
    t_load_dir();
    t_opnd_cnt();
    t_branch();
    t_ram_code();
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge i_clk_sys);
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
